// ===== design/scf_cfg.svh
// constants of the serial command front end
`ifndef SCF_CFG_SVH
`define SCF_CFG_SVH

`define SCF_CMD_RST    8'h00
`define SCF_RS_MSB     5
`define SCF_RS_LSB     4
`define SCF_RW_BIT     3
`define SCF_CONTINUOUS_READOUT_BIT  2
`define SCF_CH_MSB     1
`define SCF_CH_LSB     0
`define SCF_RS_CMD     2'h0
`define SCF_RS_MODE    2'h1
`define SCF_RS_RSVD    2'h2
`define SCF_RS_DATA    2'h3
`define SCF_CH_RST     2'h0
`define SCF_ONES_LAST  6'h1f
`define SCF_RX_LAST    3'h7
`define SCF_LEN_BYTE   5'h08
`define SCF_LEN_DATA   5'h10
`define SCF_RDY_RST    1'b1
`define SCF_MODE_RST   8'h00
`define SCF_STAT_RDY   7

`endif

// ===== design/scf_front_end.sv
// serial command front end: command word, register access, continuous readout
`timescale 1ns/1ps
`include "scf_cfg.svh"

// Overview of operation
// RULE1: eight-bit command register, write only
// RULE2: host starts each transaction with command
// RULE3: command picks direction and target register
// RULE4: idle awaiting command after access or reset
// RULE5: 32 ones on data input reset all
// RULE6: command shifted most significant bit first
// RULE7: hold at first bit while gate is one
// RULE8: host writes zero into bit six
// RULE9: bits five, four select target register
// RULE10: select codes command/status, mode, reserved, result
// RULE11: bit three zero writes, one reads
// RULE12: continuous readout streams result without commands
// RULE13: host enters readout with 001111XX
// RULE14: host exits with 001110XX while line low
// RULE15: input decoded during continuous readout
// RULE16: 32 ones reset during continuous readout
// RULE17: host keeps input low during readout
// RULE18: low two bits select input channel
// RULE19: channel change resets filter, restarts conversion
// RULE20: command bits zero after reset
// RULE21: output bits change after falling clock edge
// RULE22: line driven low when result ready
// RULE23: line released while chip select high
// RULE24: input sampled on rising edge, select low
module scf_front_end (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  mode_i,
  input  wire logic [15:0] result_i,
  input  wire logic        result_valid_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             rdy_n_o,
  output logic [1:0]       channel_o,
  output logic             filter_rst_o,
  output logic             dev_rst_o,
  output logic             mode_wr_o,
  output logic [7:0]       mode_wdata_o
);

  // transfer length of the selected register
  function automatic logic [4:0] scf_len(input logic [1:0] rs);
    scf_len = (rs == `SCF_RS_DATA) ? `SCF_LEN_DATA : `SCF_LEN_BYTE;
  endfunction

  logic sclk_rise;  // synced serial clock rising edge
  logic sclk_fall;  // synced serial clock falling edge
  logic cs_n_s;     // synced chip select
  logic din_s;      // synced data input

  scf_pin_sync u_sync (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .din_i       (din_i),
    .sclk_rise_o (sclk_rise),
    .sclk_fall_o (sclk_fall),
    .cs_n_o      (cs_n_s),
    .din_o       (din_s)
  );

  scf_pkg::scf_state_e state_q, state_d;  // interface sequencer
  logic [7:0]  cmd_q, cmd_d;              // command word, never read back
  logic [1:0]  chan_q, chan_d;            // selected input channel
  logic [6:0]  rx_sh_q;                   // incoming bits
  logic [2:0]  rx_cnt_q, rx_cnt_d;        // bit pointer into a word
  logic [15:0] tx_q;                      // outgoing bits
  logic [4:0]  tx_cnt_q, tx_cnt_d;        // bits sent so far
  logic [5:0]  ones_q;                    // consecutive ones seen
  logic [15:0] result_q;                  // latest conversion result
  logic        rdy_n_q, rdy_n_d;          // low while a fresh result waits
  logic        dout_q, dout_d;            // line level
  logic        filt_q, filt_d;            // filter reset pulse
  logic        dev_q;                     // device reset pulse
  logic        mwr_q, mwr_d;              // mode write pulse
  logic [7:0]  mwd_q, mwd_d;              // mode write data

  // edges only count while selected
  wire logic srise = sclk_rise & ~cs_n_s; // RULE24
  wire logic sfall = sclk_fall & ~cs_n_s;

  // state decode
  wire logic st_cmd  = (state_q == scf_pkg::ST_CMD);
  wire logic st_wr   = (state_q == scf_pkg::ST_WR);
  wire logic st_rd   = (state_q == scf_pkg::ST_RD);
  wire logic st_cont = (state_q == scf_pkg::ST_CONT);

  // escape: the 32nd one in a row
  wire logic ones_hit = srise & din_s & (ones_q == `SCF_ONES_LAST); // RULE5 RULE16

  // receive side; listens during readout too, so exit works; escape has its own ones counter
  wire logic rx_en    = st_cmd | st_wr | st_cont; // RULE15
  wire logic wen_hold = st_cmd & (rx_cnt_q == 3'h0) & din_s; // RULE7
  wire logic rx_step  = srise & rx_en & ~wen_hold;
  wire logic rx_done  = rx_step & (rx_cnt_q == `SCF_RX_LAST);
  wire logic [7:0] rx_word = {rx_sh_q, din_s}; // RULE6

  // incoming command fields; the gate bit always lands as zero
  wire logic [7:0] rx_cmd = {1'b0, rx_word[6:0]}; // RULE1
  wire logic [1:0] rx_rs  = rx_word[`SCF_RS_MSB:`SCF_RS_LSB]; // RULE9
  wire logic rx_rw    = rx_word[`SCF_RW_BIT]; // RULE11
  wire logic rx_continuous_readout = rx_word[`SCF_CONTINUOUS_READOUT_BIT];
  wire logic [1:0] rx_ch = rx_word[`SCF_CH_MSB:`SCF_CH_LSB]; // RULE18
  wire logic chan_chg = (rx_ch != chan_q);

  // exit pattern while streaming; anything else there is ignored
  wire logic exit_cmd = st_cont & rx_done & rx_rw & ~rx_continuous_readout &
                        (rx_rs == `SCF_RS_DATA);

  // latched command fields
  wire logic [1:0] cmd_rs = cmd_q[`SCF_RS_MSB:`SCF_RS_LSB]; // RULE3
  wire logic [4:0] tx_len = scf_len(cmd_rs);

  // read source per select code; reserved reads as zero
  wire logic [7:0] stat_word = {rdy_n_q, status_i[6:2], chan_q};
  wire logic [15:0] load_word =
    (cmd_rs == `SCF_RS_DATA) ? result_q :
    (cmd_rs == `SCF_RS_MODE) ? {mode_i, 8'h00} :
    (cmd_rs == `SCF_RS_CMD)  ? {stat_word, 8'h00} : 16'h0000; // RULE10

  // transmit side; streaming waits for a fresh result before a word
  wire logic tx_ok   = st_rd | (st_cont & ~(rdy_n_q & (tx_cnt_q == 5'h00)));
  wire logic tx_go   = sfall & tx_ok & (tx_cnt_q != scf_len(cmd_rs)); // RULE21
  wire logic tx_end  = srise & (st_rd | st_cont) & (tx_cnt_q == tx_len);
  wire logic tx_busy = (st_rd | st_cont) & (tx_cnt_q != 5'h00) & ~tx_end;
  wire logic [15:0] tx_word = (tx_cnt_q == 5'h00) ? load_word : tx_q;
  wire logic data_rd = tx_end & (cmd_rs == `SCF_RS_DATA); // RULE12

  // sequencer and command register
  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    chan_d  = chan_q;
    filt_d  = 1'b0;
    mwr_d   = 1'b0;
    mwd_d   = mwd_q;
    unique case (state_q)
      scf_pkg::ST_CMD: begin
        if (rx_done) begin
          cmd_d  = rx_cmd;
          chan_d = rx_ch;
          filt_d = chan_chg; // RULE19
          if (rx_rw) begin
            // continuous readout only with the result register selected
            if (rx_continuous_readout && (rx_rs == `SCF_RS_DATA)) begin
              state_d = scf_pkg::ST_CONT; // RULE12
            end else begin
              state_d = scf_pkg::ST_RD; // RULE11
            end
          end else if (rx_rs != `SCF_RS_CMD) begin
            state_d = scf_pkg::ST_WR; // RULE3
          end
        end
      end
      scf_pkg::ST_WR: begin
        if (rx_done) begin
          state_d = scf_pkg::ST_CMD; // RULE4
          // a mode write also restarts the filter; reserved is dropped
          if (cmd_rs == `SCF_RS_MODE) begin
            mwr_d  = 1'b1;
            mwd_d  = rx_word;
            filt_d = 1'b1;
          end
        end
      end
      scf_pkg::ST_RD: begin
        if (tx_end) begin
          state_d = scf_pkg::ST_CMD; // RULE4
        end
      end
      scf_pkg::ST_CONT: begin
        if (exit_cmd) begin
          state_d = scf_pkg::ST_CMD;
          cmd_d   = rx_cmd;
          chan_d  = rx_ch;
          filt_d  = chan_chg; // RULE19
        end
      end
      default: begin
        state_d = scf_pkg::ST_CMD;
      end
    endcase
    // escape overrides the state, command, channel and pulses
    if (ones_hit) begin
      state_d = scf_pkg::ST_CMD; // RULE5 RULE16
      cmd_d   = `SCF_CMD_RST; // RULE20
      chan_d  = `SCF_CH_RST;
      filt_d  = 1'b0;
      mwr_d   = 1'b0;
    end
  end

  // counters; the receive pointer wraps to zero after each word
  // an exit in mid-word drops the rest of that word, so the next read starts clean
  always_comb begin
    rx_cnt_d = rx_step ? rx_cnt_q + 3'h1 : rx_cnt_q;
    tx_cnt_d = tx_go ? tx_cnt_q + 5'h01 : tx_cnt_q;
    if (tx_end || ones_hit || exit_cmd) begin
      tx_cnt_d = 5'h00;
    end
    if (ones_hit) begin
      rx_cnt_d = 3'h0;
    end
  end

  // a new result wins over a clear in the same cycle
  assign rdy_n_d = result_valid_i ? 1'b0 :
                   (data_rd | mwr_d | ones_hit) ? 1'b1 : rdy_n_q; // RULE22

  // line level: data bit while shifting, otherwise the ready flag
  assign dout_d = tx_go ? tx_word[15] : tx_busy ? dout_q : rdy_n_d; // RULE21 RULE22

  // sequencer registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= scf_pkg::ST_CMD; // RULE4
      cmd_q   <= `SCF_CMD_RST; // RULE20
      chan_q  <= `SCF_CH_RST;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      chan_q  <= chan_d;
    end
  end

  // shift paths and counters
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_sh_q  <= 7'h00;
      rx_cnt_q <= 3'h0;
      tx_q     <= 16'h0000;
      tx_cnt_q <= 5'h00;
    end else if (clk_en_i) begin
      if (rx_step) begin
        rx_sh_q <= rx_word[6:0]; // RULE6
      end
      if (tx_go) begin
        tx_q <= {tx_word[14:0], 1'b0};
      end
      rx_cnt_q <= rx_cnt_d;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // run of ones on the input, any state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ones_q <= 6'h00;
    end else if (clk_en_i && srise) begin
      ones_q <= (din_s && !ones_hit) ? ones_q + 6'h01 : 6'h00;
    end
  end

  // result holding copy; a stream in flight keeps its own copy in tx_q
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      result_q <= 16'h0000;
    end else if (clk_en_i && result_valid_i) begin
      result_q <= result_i;
    end
  end

  // flags and pulses
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdy_n_q <= `SCF_RDY_RST;
      dout_q  <= `SCF_RDY_RST;
      filt_q  <= 1'b0;
      dev_q   <= 1'b0;
      mwr_q   <= 1'b0;
      mwd_q   <= `SCF_MODE_RST;
    end else if (clk_en_i) begin
      rdy_n_q <= rdy_n_d;
      dout_q  <= dout_d;
      filt_q  <= filt_d;
      dev_q   <= ones_hit; // RULE5
      mwr_q   <= mwr_d;
      mwd_q   <= mwd_d;
    end
  end

  // outputs; the pin floats while deselected, the flag does not
  assign dout_o       = dout_q;
  assign dout_oe_o    = ~cs_n_s; // RULE23
  assign rdy_n_o      = rdy_n_q;
  assign channel_o    = chan_q;
  assign filter_rst_o = filt_q;
  assign dev_rst_o    = dev_q;
  assign mode_wr_o    = mwr_q;
  assign mode_wdata_o = mwd_q;

  // checks
  a_escape_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE5
    clk_en_i && ones_hit |=> st_cmd && cmd_q == 8'h00 && dev_rst_o)
    else $error("escape did not reset the interface");

  a_cont_escape: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE16
    clk_en_i && st_cont && ones_hit |=> st_cmd && rdy_n_q)
    else $error("escape ignored during readout");

  a_gate_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE7
    clk_en_i && srise && st_cmd && rx_cnt_q == 3'h0 && din_s |=> rx_cnt_q == 3'h0)
    else $error("pointer left first bit on a one");

  a_cmd_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE6
    clk_en_i && st_cmd && rx_done && !ones_hit
    |=> cmd_q == {1'b0, $past(rx_sh_q[5:0]), $past(din_s)})
    else $error("command word latched wrongly");

  a_cmd_route: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE11
    clk_en_i && st_cmd && rx_done && rx_rw && !rx_continuous_readout && !ones_hit |=> st_rd)
    else $error("read command did not start a read");

  a_read_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE4
    clk_en_i && st_rd && tx_end && !ones_hit |=> st_cmd)
    else $error("interface not idle after read");

  a_chan_filter: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE19
    clk_en_i && st_cmd && rx_done && chan_chg && !ones_hit |=> filter_rst_o ##1 !filter_rst_o)
    else $error("channel change without filter reset");

  a_rdy_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE22
    clk_en_i && result_valid_i |=> !rdy_n_o)
    else $error("ready flag not set by new result");

  a_edge_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE21
    clk_en_i && tx_busy && !tx_go |=> $stable(dout_o))
    else $error("data bit changed without falling edge");

  a_hiz_cs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE23
    cs_n_s |-> !dout_oe_o)
    else $error("pin driven while deselected");

endmodule

// ===== design/scf_pin_sync.sv
// pin synchroniser and serial clock edge finder
`timescale 1ns/1ps
module scf_pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic din_i,
  output logic      sclk_rise_o,
  output logic      sclk_fall_o,
  output logic      cs_n_o,
  output logic      din_o
);

  logic [2:0] meta_q;   // first stage, read only by the second
  logic [2:0] sync_q;   // second stage: {din, cs_n, sclk}
  logic       sclk_p_q; // previous synced serial clock

  // two flops per pin; chip select and serial clock idle high, so the
  // edge finder starts at the idle level and sees no false rise after reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q   <= 3'h3;
      sync_q   <= 3'h3;
      sclk_p_q <= 1'b1;
    end else if (clk_en_i) begin
      meta_q   <= {din_i, cs_n_i, sclk_i};
      sync_q   <= meta_q;
      sclk_p_q <= sync_q[0];
    end
  end

  // edges seen from the second stage only
  assign sclk_rise_o = sync_q[0] & ~sclk_p_q;
  assign sclk_fall_o = ~sync_q[0] & sclk_p_q;
  assign cs_n_o      = sync_q[1];
  assign din_o       = sync_q[2];

endmodule

// ===== design/scf_pkg.sv
// types of the serial command front end
package scf_pkg;

  // interface sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_CMD  = 4'h1,
    ST_WR   = 4'h2,
    ST_RD   = 4'h4,
    ST_CONT = 4'h8
  } scf_state_e;

endpackage

// ===== sim/scf_host_model.sv
// host serial master model that drives the front end link
`timescale 1ns/1ps
module scf_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic sdo_i
);
  localparam real HALF = 62.5;  // half of the 125 ns link period

  // link idles with clock high, device deselected, data low
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // one bit: data changes on the fall, both sides sample on the rise
  task automatic bit_x(input logic b, output logic r);
    sclk_o = 1'b0;
    din_o  = b;
    #(HALF);
    sclk_o = 1'b1;
    r = sdo_i;
    #(HALF);
  endtask

  // a byte, first bit on the wire is bit seven; commands keep bit six zero
  task automatic send8(input logic [7:0] c);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(c[i], r);
    end
  endtask

  // read n bits while holding the input line low
  task automatic get(input int n, output logic [15:0] v);
    logic r;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      bit_x(1'b0, r);
      v = {v[14:0], r};
    end
  endtask

  // a run of ones on the input line, as used by the escape
  task automatic ones(input int n);
    logic r;
    for (int i = 0; i < n; i++) begin
      bit_x(1'b1, r);
    end
  endtask

  // chip select change, with a settling half period behind it
  task automatic sel(input logic s);
    cs_n_o = s;
    #(HALF);
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        clk_en_i;                 // freeze control
  logic [15:0] result_i;
  logic        result_valid_i;
  logic [7:0]  status_i;                 // bench status source
  logic [7:0]  mode_i;                   // bench mode contents
  logic        sclk, cs_n, din, pin;     // link wires
  logic        last_q         = 1'b1;    // last driven pin level
  wire         dout_o, dout_oe_o, rdy_n_o, filter_rst_o, dev_rst_o, mode_wr_o;
  wire  [1:0]  channel_o;
  wire  [7:0]  mode_wdata_o;
  logic [7:0]  n_frst = 8'h00;           // filter restart pulses seen
  logic [7:0]  n_drst = 8'h00;           // device reset pulses seen
  logic [7:0]  n_mwr  = 8'h00;           // mode write pulses seen
  logic [15:0] v;
  int          mismatches = 0;
  int          n_tests    = 0;

  // system clock, 100 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // released pin shows the inverse of its last level, never a stale match
  assign pin = dout_oe_o ? dout_o : ~last_q;
  always @(posedge ref_clk_i) begin
    if (dout_oe_o === 1'b1) last_q <= dout_o;
    if (filter_rst_o === 1'b1) n_frst <= n_frst + 8'h01;
    if (dev_rst_o === 1'b1) n_drst <= n_drst + 8'h01;
    if (mode_wr_o === 1'b1) n_mwr <= n_mwr + 8'h01;
  end

  scf_front_end dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .status_i(status_i),
    .mode_i(mode_i), .result_i(result_i), .result_valid_i(result_valid_i),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .rdy_n_o(rdy_n_o),
    .channel_o(channel_o), .filter_rst_o(filter_rst_o), .dev_rst_o(dev_rst_o),
    .mode_wr_o(mode_wr_o), .mode_wdata_o(mode_wdata_o));

  scf_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .sdo_i(pin));

  task automatic chk_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // wait n clocks, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // one-cycle fresh result from the converter side
  task automatic pulse(input logic [15:0] r);
    cyc(1);
    result_i = r;
    result_valid_i = 1'b1;
    cyc(1);
    result_valid_i = 1'b0;
    cyc(2);
  endtask

  // command then an 8-bit read, compared against e
  task automatic rd8(input logic [7:0] c, input logic [7:0] e, input string m);
    host.send8(c);
    host.get(8, v);
    cyc(8);
    chk_byte(v[7:0], e, m);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // whole run is about 37 us of link traffic; allow about eight times that
  initial begin
    #300000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end

  initial begin
    rst_n_i        = 1'b0;
    clk_en_i       = 1'b1;
    result_i       = 16'h0000;
    result_valid_i = 1'b0;
    status_i       = 8'h48;
    mode_i         = 8'h6c;
    cyc(2);
    rst_n_i = 1'b1;
    chk_bit(dout_oe_o, 1'b0, "pin driven while deselected");
    chk_bit(rdy_n_o, 1'b1, "ready flag after reset");
    chk_byte({6'h00, channel_o}, 8'h00, "channel after reset");
    // a command clocked while deselected must be ignored
    host.send8(8'h0b);
    host.sel(1'b0);
    cyc(4);
    chk_bit(dout_oe_o, 1'b1, "pin not driven when selected");
    $display("test reset done");

    // leading ones hold the write gate, then a status read on channel 3
    host.ones(3);
    rd8(8'h0b, {1'b1, status_i[6:2], 2'h3}, "status read");
    chk_byte({6'h00, channel_o}, 8'h03, "channel select");
    chk_byte(n_frst, 8'h01, "filter restart on channel change");
    $display("test status done");

    // mode write, mode read, reserved write and read
    host.send8(8'h13);
    host.send8(8'ha5);
    cyc(8);
    chk_byte(n_mwr, 8'h01, "mode write pulses");
    chk_byte(mode_wdata_o, 8'ha5, "mode write data");
    rd8(8'h1b, mode_i, "mode read");
    host.send8(8'h23);
    host.send8(8'h5a);
    cyc(8);
    chk_byte(n_mwr, 8'h01, "reserved write reached mode");
    rd8(8'h2b, 8'h00, "reserved read");
    mode_i = 8'h93;  // later reads see new mode contents
    $display("test registers done");

    // single result read
    pulse(16'hbeef);
    chk_bit(rdy_n_o, 1'b0, "ready flag on fresh result");
    chk_bit(dout_o, 1'b0, "line low on fresh result");
    host.send8(8'h3b);
    host.get(16, v);
    cyc(8);
    chk_word(v, 16'hbeef, "result read");
    chk_bit(rdy_n_o, 1'b1, "ready flag after result read");
    $display("test result done");

    // continuous readout: two results with no command between them
    host.send8(8'h3f);
    pulse(16'h1234);
    host.get(16, v);
    cyc(8);
    chk_word(v, 16'h1234, "stream first result");
    pulse(16'h5a0f);
    host.get(16, v);
    cyc(8);
    chk_word(v, 16'h5a0f, "stream second result");
    pulse(16'h0f0f);
    host.send8(8'h3b);
    rd8(8'h1b, mode_i, "read after stream exit");
    $display("test stream done");

    // 31 ones are not an escape, the next command still works
    host.ones(31);
    rd8(8'h1b, mode_i, "read after 31 ones");
    chk_byte(n_drst, 8'h00, "early device reset");
    // 32 ones during continuous readout reset the device
    host.send8(8'h3f);
    host.ones(32);
    cyc(8);
    chk_byte(n_drst, 8'h01, "escape reset");
    chk_byte({6'h00, channel_o}, 8'h00, "channel after escape");
    chk_bit(rdy_n_o, 1'b1, "ready flag after escape");
    rd8(8'h18, mode_i, "read after escape");
    status_i = 8'h3c;
    rd8(8'h08, {1'b1, status_i[6:2], 2'h0}, "status after escape");
    $display("test escape done");

    // deselect: pin released while the ready flag keeps working
    host.sel(1'b1);
    cyc(4);
    chk_bit(dout_oe_o, 1'b0, "pin driven after deselect");
    // clock enable low: a fresh result must not reach the flag
    clk_en_i = 1'b0;
    pulse(16'h0002);
    chk_bit(rdy_n_o, 1'b1, "ready flag moved while frozen");
    clk_en_i = 1'b1;
    pulse(16'h0001);
    chk_bit(rdy_n_o, 1'b0, "ready flag while deselected");
    $display("test deselect done");
    final_report;
  end
endmodule
